// ===== common/tx_cell_fifo_defs.vh
`ifndef TX_CELL_FIFO_DEFS_VH
`define TX_CELL_FIFO_DEFS_VH

// ----------------------------------------
// Cell and FIFO geometry
// ----------------------------------------
`define CELL_BYTES 8'h35
`define CELL_LAST 6'h34
`define FIFO_BYTES 8'hD4
`define NEAR_MARGIN 8'h04
`define IDLE_FILL 8'h00

// ----------------------------------------
// Synchroniser bundle layout
// ----------------------------------------
`define SY_W 13
`define SY_CLK 0
`define SY_DAT_LO 1
`define SY_DAT_HI 8
`define SY_WEN 9
`define SY_PAR 10
`define SY_SOC 11
`define SY_HOLD 12

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define REG_CFG 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_LEVEL 8'h0C

// ----------------------------------------
// Config fields
// ----------------------------------------
`define CFG_W 6
`define CFG_RST 6'h1C
`define CFG_ODD 0
`define CFG_NEAR 1
`define CFG_DEP_LO 2
`define CFG_DEP_HI 3
`define CFG_POL 4
`define CFG_TEST 5

// ----------------------------------------
// Status fields
// ----------------------------------------
`define STS_W 2
`define STS_PAR 0
`define STS_SOC 1

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== rtl/tx_cell_sync.v
`timescale 1ns/1ps
`default_nettype none

module tx_cell_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Pins from outside the clock domain
    input wire [W-1:0] async_in,
    // Third stage and stage agreement
    output wire [W-1:0] third,
    output wire [W-1:0] agree
);

reg [W-1:0] s1_ff;
reg [W-1:0] s2_ff;
reg [W-1:0] s3_ff;

// ----------------------------------------
// Three-stage chain; first stage feeds only the second
// ----------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        s1_ff <= {W{1'b0}};
        s2_ff <= {W{1'b0}};
        s3_ff <= {W{1'b0}};
    end else begin
        s1_ff <= async_in;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
    end
end

assign third = s3_ff;
assign agree = ~(s2_ff ^ s3_ff);

endmodule // tx_cell_sync

`default_nettype wire

// ===== rtl/tx_cell_fifo_write_port.v
`timescale 1ns/1ps
`default_nettype none
`include "tx_cell_fifo_defs.vh"

module tx_cell_fifo_write_port (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Cell writer pins
    input wire tx_write_clock,
    input wire [7:0] tx_cell_byte,
    input wire tx_byte_parity,
    input wire tx_write_enable_n,
    input wire tx_cell_start,
    output reg tx_cell_space_avail,
    // Flow control and test
    input wire tx_cell_hold,
    output reg test_vector_clock,
    // Payload side
    input wire payload_byte_req,
    output reg [7:0] payload_byte_ff,
    output reg payload_soc_ff,
    output reg payload_idle_ff,
    output reg payload_valid_ff,
    // Interrupt
    output reg irq_ff
);

// ----------------------------------------
// Declarations
// ----------------------------------------
wire [`SY_W-1:0] syn_third;
wire [`SY_W-1:0] syn_agree;
reg [`SY_W-1:0] smp_ff;
reg wclk_lvl_ff;
reg hold_lvl_ff;
reg [`CFG_W-1:0] cfg_ff;
reg [`STS_W-1:0] sts_ff;
reg [`STS_W-1:0] mask_ff;
reg [`STS_W-1:0] nxt_sts;
reg [7:0] wr_ptr_ff;
reg [7:0] rd_ptr_ff;
reg [7:0] byte_cnt_ff;
reg [5:0] wr_oct_ff;
reg [5:0] rd_oct_ff;
reg [2:0] cells_rdy_ff;
reg rd_idle_ff;
reg aw_hold_ff;
reg [7:0] aw_addr_ff;
reg w_hold_ff;
reg [31:0] w_data_ff;
reg w_strb0_ff;
wire [7:0] ent_q [0:`FIFO_BYTES-1];
wire clk_rise;
wire wr_evt;
wire [7:0] wr_byte;
wire par_err;
wire soc_err;
wire wr_do;
wire wr_cell_done;
wire cell_start;
wire hold_eff;
wire use_idle;
wire rd_do;
wire cell_take;
wire [7:0] thresh;
wire [7:0] limit;
wire avail;
wire aw_have;
wire w_have;
wire [7:0] wa;
wire [31:0] wd;
wire ws0;
wire wr_go;
wire [7:0] ra;
wire [`STS_W-1:0] clr_bits;

// ----------------------------------------
// Pin synchronisation
// ----------------------------------------
tx_cell_sync #(
    .W(`SY_W)
) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({tx_cell_hold, tx_cell_start, tx_byte_parity,
               tx_write_enable_n, tx_cell_byte, tx_write_clock}),
    .third(syn_third),
    .agree(syn_agree)
);

// Data taken from the sample just before the clock was seen high,
// so the writer's hold time after its edge does not matter
always @(posedge aclk) begin
    if (!aresetn) begin
        smp_ff <= {`SY_W{1'b0}};
        wclk_lvl_ff <= 1'b0;
        hold_lvl_ff <= 1'b0;
    end else begin
        smp_ff <= syn_third;
        if (syn_agree[`SY_CLK]) begin
            wclk_lvl_ff <= syn_third[`SY_CLK];
        end
        if (syn_agree[`SY_HOLD]) begin
            hold_lvl_ff <= syn_third[`SY_HOLD];
        end
    end
end

assign clk_rise = syn_agree[`SY_CLK] & syn_third[`SY_CLK] & ~wclk_lvl_ff;
assign wr_evt = clk_rise & ~smp_ff[`SY_WEN];
assign wr_byte = smp_ff[`SY_DAT_HI:`SY_DAT_LO];

// ----------------------------------------
// Write side checks
// ----------------------------------------
assign par_err = wr_evt
    & (smp_ff[`SY_PAR] != (^wr_byte ^ cfg_ff[`CFG_ODD]));
assign soc_err = wr_evt & smp_ff[`SY_SOC]
    & (wr_oct_ff != 6'h00);

// Dropping a byte at full keeps the stored cells intact
assign wr_do = wr_evt & (byte_cnt_ff != `FIFO_BYTES);
assign wr_cell_done = wr_do & (wr_oct_ff == `CELL_LAST);

always @(posedge aclk) begin
    if (!aresetn) begin
        wr_ptr_ff <= 8'h00;
        wr_oct_ff <= 6'h00;
    end else if (wr_do) begin
        wr_ptr_ff <= (wr_ptr_ff == `FIFO_BYTES - 8'h01) ? 8'h00
            : wr_ptr_ff + 8'h01;
        // Stray markers never realign; counting sets cell bounds
        wr_oct_ff <= wr_cell_done ? 6'h00 : wr_oct_ff + 6'h01;
    end
end

// ----------------------------------------
// Cell storage, four cells of flops
// ----------------------------------------
genvar gi;
generate
    for (gi = 0; gi < `FIFO_BYTES; gi = gi + 1) begin : g_ent
        localparam integer IDX = gi;
        reg [7:0] ent_ff;
        always @(posedge aclk) begin
            if (!aresetn) begin
                ent_ff <= 8'h00;
            end else if (wr_do && {24'h000000, wr_ptr_ff} == IDX) begin
                ent_ff <= wr_byte;
            end
        end
        assign ent_q[gi] = ent_ff;
    end
endgenerate

// ----------------------------------------
// Payload side reader
// ----------------------------------------
assign hold_eff = hold_lvl_ff & ~cfg_ff[`CFG_TEST];
assign cell_start = payload_byte_req & (rd_oct_ff == 6'h00);
// Decision made only at a cell boundary, never mid-cell
assign use_idle = cell_start ? (hold_eff | (cells_rdy_ff == 3'h0))
    : rd_idle_ff;
assign rd_do = payload_byte_req & ~use_idle;
assign cell_take = cell_start & ~use_idle;

always @(posedge aclk) begin
    if (!aresetn) begin
        rd_ptr_ff <= 8'h00;
        rd_oct_ff <= 6'h00;
        rd_idle_ff <= 1'b1;
        payload_byte_ff <= 8'h00;
        payload_soc_ff <= 1'b0;
        payload_idle_ff <= 1'b0;
        payload_valid_ff <= 1'b0;
    end else begin
        payload_valid_ff <= payload_byte_req;
        payload_soc_ff <= cell_start;
        payload_idle_ff <= use_idle;
        payload_byte_ff <= rd_do ? ent_q[rd_ptr_ff] : `IDLE_FILL;
        if (cell_start) begin
            rd_idle_ff <= use_idle;
        end
        if (payload_byte_req) begin
            rd_oct_ff <= (rd_oct_ff == `CELL_LAST) ? 6'h00
                : rd_oct_ff + 6'h01;
        end
        if (rd_do) begin
            rd_ptr_ff <= (rd_ptr_ff == `FIFO_BYTES - 8'h01) ? 8'h00
                : rd_ptr_ff + 8'h01;
        end
    end
end

// ----------------------------------------
// Occupancy
// ----------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        byte_cnt_ff <= 8'h00;
        cells_rdy_ff <= 3'h0;
    end else begin
        if (wr_do && !rd_do) begin
            byte_cnt_ff <= byte_cnt_ff + 8'h01;
        end else if (rd_do && !wr_do) begin
            byte_cnt_ff <= byte_cnt_ff - 8'h01;
        end
        if (wr_cell_done && !cell_take) begin
            cells_rdy_ff <= cells_rdy_ff + 3'h1;
        end else if (cell_take && !wr_cell_done) begin
            cells_rdy_ff <= cells_rdy_ff - 3'h1;
        end
    end
end

// ----------------------------------------
// Space available flag
// ----------------------------------------
assign thresh = ({6'h00, cfg_ff[`CFG_DEP_HI:`CFG_DEP_LO]} + 8'h01)
    * `CELL_BYTES;
assign limit = cfg_ff[`CFG_NEAR] ? thresh - `NEAR_MARGIN : thresh;
// Only the flag follows the depth; writes still go to physical room
assign avail = byte_cnt_ff < limit;

always @(posedge aclk) begin
    if (!aresetn) begin
        tx_cell_space_avail <= 1'b1;
        test_vector_clock <= 1'b0;
    end else begin
        if (clk_rise) begin
            tx_cell_space_avail <= avail ^ ~cfg_ff[`CFG_POL];
        end
        test_vector_clock <= hold_lvl_ff & cfg_ff[`CFG_TEST];
    end
end

// ----------------------------------------
// AXI4-Lite write channel
// ----------------------------------------
assign s_axi_awready = ~aw_hold_ff & ~s_axi_bvalid;
assign s_axi_wready = ~w_hold_ff & ~s_axi_bvalid;
assign aw_have = aw_hold_ff | (s_axi_awvalid & s_axi_awready);
assign w_have = w_hold_ff | (s_axi_wvalid & s_axi_wready);
assign wa = aw_hold_ff ? aw_addr_ff : {s_axi_awaddr[7:2], 2'b00};
assign wd = w_hold_ff ? w_data_ff : s_axi_wdata;
assign ws0 = w_hold_ff ? w_strb0_ff : s_axi_wstrb[0];
assign wr_go = aw_have & w_have & ~s_axi_bvalid;
assign clr_bits = (wr_go && wa == `REG_STATUS && ws0) ? wd[`STS_W-1:0]
    : {`STS_W{1'b0}};

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_hold_ff <= 1'b0;
        aw_addr_ff <= 8'h00;
        w_hold_ff <= 1'b0;
        w_data_ff <= 32'h00000000;
        w_strb0_ff <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
    end else if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa > `REG_LEVEL) ? `RESP_SLVERR : `RESP_OKAY;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_ff <= 1'b1;
            aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb0_ff <= s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ----------------------------------------
// Control registers and sticky status
// ----------------------------------------
always @* begin
    nxt_sts = sts_ff & ~clr_bits;
    // A new event in the clearing cycle survives
    nxt_sts[`STS_PAR] = nxt_sts[`STS_PAR] | par_err;
    nxt_sts[`STS_SOC] = nxt_sts[`STS_SOC] | soc_err;
end

always @(posedge aclk) begin
    if (!aresetn) begin
        cfg_ff <= `CFG_RST;
        mask_ff <= {`STS_W{1'b0}};
        sts_ff <= {`STS_W{1'b0}};
        irq_ff <= 1'b0;
    end else begin
        sts_ff <= nxt_sts;
        irq_ff <= |(nxt_sts & mask_ff);
        if (wr_go && ws0 && wa == `REG_CFG) begin
            cfg_ff <= wd[`CFG_W-1:0];
        end
        if (wr_go && ws0 && wa == `REG_MASK) begin
            mask_ff <= wd[`STS_W-1:0];
        end
    end
end

// ----------------------------------------
// AXI4-Lite read channel
// ----------------------------------------
assign s_axi_arready = ~s_axi_rvalid;
assign ra = {s_axi_araddr[7:2], 2'b00};

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (ra)
            `REG_CFG: s_axi_rdata <= {26'h0000000, cfg_ff};
            `REG_STATUS: s_axi_rdata <= {30'h00000000, sts_ff};
            `REG_MASK: s_axi_rdata <= {30'h00000000, mask_ff};
            `REG_LEVEL: s_axi_rdata <= {21'h000000, cells_rdy_ff, byte_cnt_ff};
            default: begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule // tx_cell_fifo_write_port

`default_nettype wire

// ===== tb/tx_cell_fifo_write_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_cell_fifo_defs.vh"
module tx_cell_fifo_write_port_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Payload side
    input wire logic payload_byte_req,
    input wire logic [7:0] payload_byte_ff,
    input wire logic payload_soc_ff,
    input wire logic payload_idle_ff,
    input wire logic payload_valid_ff
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----
    // Octet position of the payload stream
    // ----
    logic [5:0] oct_ff;
    logic idle_ff;
    always @(posedge aclk) begin
        if (!aresetn) begin
            oct_ff <= 6'h00;
            idle_ff <= 1'b0;
        end else if (payload_valid_ff) begin
            oct_ff <= (oct_ff == 6'h34) ? 6'h00 : oct_ff + 6'h01;
            idle_ff <= payload_soc_ff ? payload_idle_ff : idle_ff;
        end
    end
    // ----
    // Properties
    // ----
    AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("no write response");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    AST_B_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    AST_PAY_TIMING: assert property (1'b1 |=> payload_valid_ff == $past(payload_byte_req))
        else $error("payload valid not one cycle after request");
    AST_SOC_COUNT: assert property (payload_valid_ff |-> payload_soc_ff == (oct_ff == 6'h00))
        else $error("cell start off the 53 octet grid");
    AST_IDLE_CELL: assert property (payload_valid_ff && !payload_soc_ff
        |-> payload_idle_ff == idle_ff) else $error("idle flag changed inside a cell");
    AST_IDLE_ZERO: assert property (payload_valid_ff && payload_idle_ff
        |-> payload_byte_ff == 8'h00) else $error("idle byte not zero");
    cover property (payload_valid_ff && payload_soc_ff && !payload_idle_ff);
    cover property (payload_valid_ff && payload_soc_ff && payload_idle_ff);
    cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule // tx_cell_fifo_write_port_monitor
`default_nettype wire

// ===== tb/tx_cell_writer.sv
`timescale 1ns/1ps
`default_nettype none
module tx_cell_writer (
    // Writer pins
    output logic tx_write_clock,
    output logic [7:0] tx_cell_byte,
    output logic tx_byte_parity,
    output logic tx_write_enable_n,
    output logic tx_cell_start
);
    initial begin
        tx_write_clock = 1'b0;
        tx_cell_byte = 8'h5A;
        tx_byte_parity = 1'b1;
        tx_write_enable_n = 1'b1;
        tx_cell_start = 1'b0;
    end
    // ----
    // One byte per writer clock, clock stands still between bytes
    // ----
    task automatic put(input logic [7:0] b, input logic s, input logic bad, input logic en);
        tx_cell_byte = b;
        tx_byte_parity = ^b ^ bad;
        tx_write_enable_n = !en;
        tx_cell_start = s;
        #31.0 tx_write_clock = 1'b1;
        #62.5 tx_write_clock = 1'b0;
        // Released lines show no stale byte
        tx_write_enable_n = 1'b1;
        tx_cell_byte = ~b;
        tx_byte_parity = ~tx_byte_parity;
        tx_cell_start = 1'b0;
        #31.5;
    endtask
endmodule // tx_cell_writer
`default_nettype wire

// ===== tb/tx_cell_fifo_write_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_cell_fifo_defs.vh"
module tx_cell_fifo_write_port_test;
    // ----
    // Signals
    // ----
    logic aclk = 1'b0, aresetn = 1'b0, tx_cell_hold = 1'b0, payload_byte_req = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire tx_write_clock, tx_byte_parity, tx_write_enable_n, tx_cell_start;
    wire [7:0] tx_cell_byte, payload_byte_ff;
    wire tx_cell_space_avail, test_vector_clock, payload_soc_ff, payload_idle_ff;
    wire payload_valid_ff, irq_ff;
    int n_errors = 0, n_checks = 0;
    always #4 aclk = ~aclk;
    tx_cell_fifo_write_port i_tx_cell_fifo_write_port (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .tx_write_clock, .tx_cell_byte, .tx_byte_parity, .tx_write_enable_n,
        .tx_cell_start, .tx_cell_space_avail, .tx_cell_hold, .test_vector_clock,
        .payload_byte_req, .payload_byte_ff, .payload_soc_ff, .payload_idle_ff,
        .payload_valid_ff, .irq_ff);
    tx_cell_writer i_tx_cell_writer (.tx_write_clock, .tx_cell_byte, .tx_byte_parity,
        .tx_write_enable_n, .tx_cell_start);
    // ----
    // Shared tasks
    // ----
    task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rst;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid & s_axi_bready;
            if (tb) chk("bresp", s_axi_bresp, er);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
        end while (!tb);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid & s_axi_rready;
            if (tr) chk($sformatf("reg %h", a), {s_axi_rresp, s_axi_rdata}, {er, ed});
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
        end while (!tr);
    endtask
    task automatic fill(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) i_tx_cell_writer.put(base + 8'(i), i % 53 == 0, 1'b0, 1'b1);
    endtask
    task automatic avail(input logic e);
        @(negedge aclk);
        chk("avail", tx_cell_space_avail, e);
    endtask
    task automatic drain(input logic idle, input logic [7:0] base);
        for (int i = 0; i <= 53; i++) begin
            @(posedge aclk);
            payload_byte_req <= (i < 53);
            #1;
            if (i > 0) chk("payload", {payload_valid_ff, payload_soc_ff, payload_idle_ff,
                payload_byte_ff}, {1'b1, i == 1, idle, idle ? 8'h00 : base + 8'(i - 1)});
        end
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_regs;
        rd(`REG_CFG, 32'h1C, `RESP_OKAY);
        rd(`REG_LEVEL, 32'h0, `RESP_OKAY);
        rd(8'h10, 32'h0, `RESP_SLVERR);
        wr(8'h10, 32'hFF, `RESP_SLVERR);
        rd(`REG_CFG, 32'h1C, `RESP_OKAY);
        $display("test regs done");
    endtask
    task automatic t_cell;
        // Bad parity at octet 5, stray start at octet 10, a disabled edge before octet 52
        for (int i = 0; i < 52; i++) i_tx_cell_writer.put(8'(i), i == 0 || i == 10, i == 5, 1'b1);
        i_tx_cell_writer.put(8'h77, 1'b1, 1'b0, 1'b0);
        rd(`REG_LEVEL, 32'h34, `RESP_OKAY);
        drain(1'b1, 8'h00);
        i_tx_cell_writer.put(8'h34, 1'b0, 1'b0, 1'b1);
        rd(`REG_LEVEL, 32'h135, `RESP_OKAY);
        rd(`REG_STATUS, 32'h3, `RESP_OKAY);
        wr(`REG_MASK, 32'h3, `RESP_OKAY);
        @(negedge aclk) chk("irq", irq_ff, 1'b1);
        wr(`REG_STATUS, 32'h3, `RESP_OKAY);
        @(negedge aclk) chk("irq", irq_ff, 1'b0);
        drain(1'b0, 8'h00);
        wr(`REG_CFG, 32'h1D, `RESP_OKAY);
        i_tx_cell_writer.put(8'h3C, 1'b0, 1'b1, 1'b1);
        rd(`REG_STATUS, 32'h0, `RESP_OKAY);
        i_tx_cell_writer.put(8'h3C, 1'b0, 1'b0, 1'b1);
        rd(`REG_STATUS, 32'h1, `RESP_OKAY);
        $display("test cell done");
    endtask
    task automatic t_avail;
        rst();
        wr(`REG_CFG, 32'h12, `RESP_OKAY);
        fill(49, 8'h00);
        avail(1'b1);
        fill(1, 8'h31);
        avail(1'b0);
        wr(`REG_CFG, 32'h10, `RESP_OKAY);
        i_tx_cell_writer.put(8'h00, 1'b0, 1'b0, 1'b0);
        avail(1'b1);
        fill(4, 8'h32);
        avail(1'b0);
        rd(`REG_LEVEL, 32'h136, `RESP_OKAY);
        wr(`REG_CFG, 32'h00, `RESP_OKAY);
        i_tx_cell_writer.put(8'h00, 1'b0, 1'b0, 1'b0);
        avail(1'b1);
        $display("test avail done");
    endtask
    task automatic t_full;
        rst();
        fill(213, 8'h00);
        avail(1'b0);
        rd(`REG_LEVEL, 32'h4D4, `RESP_OKAY);
        for (int k = 0; k < 4; k++) drain(1'b0, 8'(53 * k));
        drain(1'b1, 8'h00);
        $display("test full done");
    endtask
    task automatic t_hold;
        fill(53, 8'h40);
        @(posedge aclk) tx_cell_hold <= 1'b1;
        repeat (10) @(posedge aclk);
        drain(1'b1, 8'h00);
        wr(`REG_CFG, 32'h3C, `RESP_OKAY);
        @(negedge aclk) chk("vector clock", test_vector_clock, 1'b1);
        wr(`REG_CFG, 32'h1C, `RESP_OKAY);
        @(negedge aclk) chk("vector clock", test_vector_clock, 1'b0);
        @(posedge aclk) tx_cell_hold <= 1'b0;
        repeat (10) @(posedge aclk);
        drain(1'b0, 8'h40);
        $display("test hold done");
    endtask
    // ----
    // Run
    // ----
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        rst();
        t_regs();
        t_cell();
        t_avail();
        t_full();
        t_hold();
        stop_test();
    end
    initial begin
        #300us;
        n_errors++;
        stop_test();
    end
endmodule // tx_cell_fifo_write_port_test
bind tx_cell_fifo_write_port tx_cell_fifo_write_port_monitor i_tx_cell_fifo_write_port_monitor (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .payload_byte_req, .payload_byte_ff,
    .payload_soc_ff, .payload_idle_ff, .payload_valid_ff);
`default_nettype wire
